/* File: src/gpio_consts.vh */
`ifndef GPIO_CONSTS_VH
`define GPIO_CONSTS_VH

// Register byte offsets
`define OFS_PIN_DIRECTION 8'h00
`define OFS_OUTPUT_LATCH 8'h04
`define OFS_ALT_FUNCTION_SELECT 8'h08
`define OFS_PIN_LEVEL 8'h0C
`define OFS_EXT_ADDR 8'h10
`define OFS_EXT_WDATA 8'h14
`define OFS_EXT_CTRL 8'h18
`define OFS_EXT_STATUS 8'h1C

// Reset values
`define RST_PIN_DIRECTION 16'h0000
`define RST_OUTPUT_LATCH 16'h0000
`define RST_ALT_FUNCTION_SELECT 16'h0000

// Bits that may act as general I/O (10, 11, 12 and 15 are bus strobes only)
`define GPIO_MASK 16'h63FF

// Strobe positions on the second port
`define BIT_ADDR_LATCH 10
`define BIT_WRITE_STROBE 11
`define BIT_HIGH_BYTE 12
`define BIT_READ_STROBE 15

// External access control fields
`define CTRL_GO 0
`define CTRL_WRITE 1
`define CTRL_BYTE 2
`define STATUS_BUSY 16

// External bus phase lengths in clock cycles
`define ADDR_PHASE_CYCLES 4'h2
`define HOLD_PHASE_CYCLES 4'h1
`define STROBE_PHASE_CYCLES 4'h4

// AXI responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

/* File: src/pin_sync.v */
// Two-stage synchroniser for asynchronous pin inputs
module pin_sync #(
   parameter WIDTH = 16
) (
   input wire clk,
   input wire rst_n,
   input wire [WIDTH-1:0] async_in,
   output reg [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] meta_reg;

   // First stage feeds only the second stage
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= {WIDTH{1'b0}};
         sync_out <= {WIDTH{1'b0}};
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end

endmodule // pin_sync

/* File: src/bus_gpio_port.v */
`include "gpio_consts.vh"

// Notes on behaviour
// - 16-bit multiplexed address and data port
// - Address latch strobe marks address on bus
// - Active-low read and write strobes
// - High-byte select with address bit zero
// - Second port: 16 bits, 12 general I/O
// - Bits 10,11,12,15 carry bus strobes
// - Cleared direction bit makes high-impedance input
// - Set direction bit makes output, per pin
// - Write to input updates latch, no drive
// - Reading input pin returns pin level
// - Write to output latches and drives pin
// - Reading output pin returns latch contents
// - Alternate-select register hands pin to peripheral
// - Pins 0-7 carry their listed peripherals
// - Pins 8,9,13,14 carry sync/select outputs
// - Pins 10,11,12,15 carry bus strobes
module bus_gpio_port (
   input wire CLK,
   input wire NRST,
   input wire [7:0] S_AXI_AWADDR,
   input wire S_AXI_AWVALID,
   output reg S_AXI_AWREADY,
   input wire [31:0] S_AXI_WDATA,
   input wire [3:0] S_AXI_WSTRB,
   input wire S_AXI_WVALID,
   output reg S_AXI_WREADY,
   output reg [1:0] S_AXI_BRESP,
   output reg S_AXI_BVALID,
   input wire S_AXI_BREADY,
   input wire [7:0] S_AXI_ARADDR,
   input wire S_AXI_ARVALID,
   output reg S_AXI_ARREADY,
   output reg [31:0] S_AXI_RDATA,
   output reg [1:0] S_AXI_RRESP,
   output reg S_AXI_RVALID,
   input wire S_AXI_RREADY,
   input wire [15:0] AD_IN,
   output reg [15:0] AD_OUT,
   output reg [15:0] AD_OE,
   input wire [15:0] PB_IN,
   output reg [15:0] PB_OUT,
   output reg [15:0] PB_OE,
   input wire UART_TX_OUT,
   input wire E_STROBE_OUT,
   input wire UART_CLOCK_PIN,
   input wire TIMER_TWO_PIN,
   input wire TIMER_THREE_PIN,
   input wire SERIAL_DATA_OUT,
   input wire SERIAL_CLOCK_OUT,
   input wire HOLD_ACK_OUT,
   input wire [3:0] SYNC_OR_SELECT_OUT
);

   // External access engine states
   localparam ST_IDLE = 4'b0001;
   localparam ST_ADDR = 4'b0010;
   localparam ST_HOLD = 4'b0100;
   localparam ST_STRB = 4'b1000;

   reg rst_meta_reg;
   reg rst_n_reg;
   reg [15:0] pin_direction_reg;
   reg [15:0] output_latch_reg;
   reg [15:0] alt_function_select_reg;
   reg [15:0] ext_addr_reg;
   reg [15:0] ext_wdata_reg;
   reg [15:0] ext_rdata_reg;
   reg ext_write_reg;
   reg ext_byte_reg;
   reg [3:0] state_reg;
   reg [3:0] phase_cnt_reg;
   reg addr_latch_reg;
   reg write_strobe_n_reg;
   reg read_strobe_n_reg;
   reg high_byte_select_reg;
   reg aw_full_reg;
   reg w_full_reg;
   reg [7:0] aw_addr_reg;
   reg [31:0] w_data_reg;
   reg [3:0] w_strb_reg;
   reg [15:0] pb_out_next;
   reg [15:0] pb_oe_next;
   reg [31:0] rd_value;
   reg rd_hit;
   wire [15:0] pb_level;
   wire [15:0] ad_level;
   wire [15:0] alt_src;
   wire [15:0] dir_eff;
   wire do_write;
   wire start_go;

   // Merge a 32-bit write into a 16-bit register under byte strobes
   function [15:0] merge16;
      input [15:0] old;
      input [31:0] data;
      input [3:0] strb;
      begin
         merge16[7:0] = strb[0] ? data[7:0] : old[7:0];
         merge16[15:8] = strb[1] ? data[15:8] : old[15:8];
      end
   endfunction

   // Reset released through two flops; assertion stays asynchronous
   always @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         rst_meta_reg <= 1'b0;
         rst_n_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n_reg <= rst_meta_reg;
      end
   end

   // Pin levels come from outside the clock domain
   pin_sync #(.WIDTH(16)) u_pb_sync (
      .clk(CLK),
      .rst_n(rst_n_reg),
      .async_in(PB_IN),
      .sync_out(pb_level)
   );

   pin_sync #(.WIDTH(16)) u_ad_sync (
      .clk(CLK),
      .rst_n(rst_n_reg),
      .async_in(AD_IN),
      .sync_out(ad_level)
   );

   // Write channel: address and data taken in either order
   assign do_write = aw_full_reg && w_full_reg && !S_AXI_BVALID;
   assign start_go = do_write && (aw_addr_reg == `OFS_EXT_CTRL) && w_strb_reg[0] &&
      w_data_reg[`CTRL_GO] && state_reg[0];

   always @(posedge CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         S_AXI_AWREADY <= 1'b0;
         S_AXI_WREADY <= 1'b0;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= `RESP_OKAY;
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
      end else begin
         S_AXI_AWREADY <= !aw_full_reg && !(S_AXI_AWVALID && S_AXI_AWREADY);
         S_AXI_WREADY <= !w_full_reg && !(S_AXI_WVALID && S_AXI_WREADY);
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= {S_AXI_AWADDR[7:2], 2'b00};
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_full_reg <= 1'b1;
            w_data_reg <= S_AXI_WDATA;
            w_strb_reg <= S_AXI_WSTRB;
         end
         if (do_write) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            case (aw_addr_reg)
               `OFS_PIN_DIRECTION, `OFS_OUTPUT_LATCH, `OFS_ALT_FUNCTION_SELECT,
               `OFS_PIN_LEVEL, `OFS_EXT_ADDR, `OFS_EXT_WDATA, `OFS_EXT_CTRL,
               `OFS_EXT_STATUS: begin
                  S_AXI_BRESP <= `RESP_OKAY;
               end
               default: begin
                  S_AXI_BRESP <= `RESP_SLVERR;
               end
            endcase
         end else if (S_AXI_BVALID && S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
         end
      end
   end

   // Software registers; direction bits of strobe-only pins stay clear
   always @(posedge CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         pin_direction_reg <= `RST_PIN_DIRECTION;
         output_latch_reg <= `RST_OUTPUT_LATCH;
         alt_function_select_reg <= `RST_ALT_FUNCTION_SELECT;
         ext_addr_reg <= 16'h0000;
         ext_wdata_reg <= 16'h0000;
      end else if (do_write) begin
         case (aw_addr_reg)
            `OFS_PIN_DIRECTION: begin
               pin_direction_reg <= merge16(pin_direction_reg, w_data_reg,
                  w_strb_reg) & `GPIO_MASK;
            end
            `OFS_OUTPUT_LATCH: begin
               // Latch takes every write whatever the direction or function
               output_latch_reg <= merge16(output_latch_reg, w_data_reg,
                  w_strb_reg);
            end
            `OFS_ALT_FUNCTION_SELECT: begin
               alt_function_select_reg <= merge16(alt_function_select_reg,
                  w_data_reg, w_strb_reg);
            end
            `OFS_EXT_ADDR: begin
               ext_addr_reg <= merge16(ext_addr_reg, w_data_reg, w_strb_reg);
            end
            `OFS_EXT_WDATA: begin
               ext_wdata_reg <= merge16(ext_wdata_reg, w_data_reg, w_strb_reg);
            end
            default: begin
            end
         endcase
      end
   end

   // Read decode; input pins show the pad, output pins the latch
   assign dir_eff = pin_direction_reg & `GPIO_MASK;

   always @* begin
      rd_hit = 1'b1;
      rd_value = 32'h0000_0000;
      // Decode at full address width; the byte lane bits are ignored
      case (S_AXI_ARADDR & 8'hFC)
         `OFS_PIN_DIRECTION: rd_value[15:0] = pin_direction_reg;
         `OFS_OUTPUT_LATCH: begin
            rd_value[15:0] = (dir_eff & output_latch_reg) |
               (~dir_eff & pb_level);
         end
         `OFS_ALT_FUNCTION_SELECT: rd_value[15:0] = alt_function_select_reg;
         `OFS_PIN_LEVEL: rd_value[15:0] = pb_level;
         `OFS_EXT_ADDR: rd_value[15:0] = ext_addr_reg;
         `OFS_EXT_WDATA: rd_value[15:0] = ext_wdata_reg;
         `OFS_EXT_CTRL: rd_value[2:0] = {ext_byte_reg, ext_write_reg, 1'b0};
         `OFS_EXT_STATUS: begin
            rd_value[15:0] = ext_rdata_reg;
            rd_value[`STATUS_BUSY] = !state_reg[0];
         end
         default: rd_hit = 1'b0;
      endcase
   end

   // Read channel: one read under way; answer one cycle after acceptance
   always @(posedge CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= 32'h0000_0000;
         S_AXI_RRESP <= `RESP_OKAY;
      end else begin
         S_AXI_ARREADY <= !S_AXI_RVALID && !(S_AXI_ARVALID && S_AXI_ARREADY);
         if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA <= rd_value;
            S_AXI_RRESP <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
         end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
         end
      end
   end

   // External access engine: address phase, hold, then strobe phase
   always @(posedge CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         state_reg <= ST_IDLE;
         phase_cnt_reg <= 4'h0;
         ext_write_reg <= 1'b0;
         ext_byte_reg <= 1'b0;
         ext_rdata_reg <= 16'h0000;
         addr_latch_reg <= 1'b0;
         write_strobe_n_reg <= 1'b1;
         read_strobe_n_reg <= 1'b1;
         high_byte_select_reg <= 1'b0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (start_go) begin
                  ext_write_reg <= w_data_reg[`CTRL_WRITE];
                  ext_byte_reg <= w_data_reg[`CTRL_BYTE];
                  // Odd byte or whole word needs the upper lane
                  high_byte_select_reg <= !w_data_reg[`CTRL_BYTE] ||
                     ext_addr_reg[0];
                  addr_latch_reg <= 1'b1;
                  phase_cnt_reg <= `ADDR_PHASE_CYCLES - 4'h1;
                  state_reg <= ST_ADDR;
               end
            end
            ST_ADDR: begin
               if (phase_cnt_reg == 4'h0) begin
                  // Address stays on the bus past the falling latch edge
                  addr_latch_reg <= 1'b0;
                  phase_cnt_reg <= `HOLD_PHASE_CYCLES - 4'h1;
                  state_reg <= ST_HOLD;
               end else begin
                  phase_cnt_reg <= phase_cnt_reg - 4'h1;
               end
            end
            ST_HOLD: begin
               if (phase_cnt_reg == 4'h0) begin
                  write_strobe_n_reg <= !ext_write_reg;
                  read_strobe_n_reg <= ext_write_reg;
                  phase_cnt_reg <= `STROBE_PHASE_CYCLES - 4'h1;
                  state_reg <= ST_STRB;
               end else begin
                  phase_cnt_reg <= phase_cnt_reg - 4'h1;
               end
            end
            ST_STRB: begin
               if (phase_cnt_reg == 4'h0) begin
                  if (!ext_write_reg) begin
                     ext_rdata_reg <= ad_level;
                  end
                  write_strobe_n_reg <= 1'b1;
                  read_strobe_n_reg <= 1'b1;
                  high_byte_select_reg <= 1'b0;
                  state_reg <= ST_IDLE;
               end else begin
                  phase_cnt_reg <= phase_cnt_reg - 4'h1;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // Multiplexed bus pins: address first, then write data or released
   always @(posedge CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         AD_OUT <= 16'h0000;
         AD_OE <= 16'h0000;
      end else begin
         if (state_reg[1] || state_reg[2]) begin
            AD_OUT <= ext_addr_reg;
            AD_OE <= 16'hFFFF;
         end else if (state_reg[3] && ext_write_reg) begin
            AD_OUT <= ext_wdata_reg;
            AD_OE <= 16'hFFFF;
         end else begin
            AD_OUT <= 16'h0000;
            AD_OE <= 16'h0000;
         end
      end
   end

   // Peripheral sources for each pin when its alternate function is on
   assign alt_src[7:0] = {HOLD_ACK_OUT, SERIAL_CLOCK_OUT, SERIAL_DATA_OUT,
      TIMER_THREE_PIN, TIMER_TWO_PIN, UART_CLOCK_PIN, E_STROBE_OUT,
      UART_TX_OUT};
   assign alt_src[9:8] = SYNC_OR_SELECT_OUT[1:0];
   assign alt_src[14:13] = SYNC_OR_SELECT_OUT[3:2];
   assign alt_src[`BIT_ADDR_LATCH] = addr_latch_reg;
   assign alt_src[`BIT_WRITE_STROBE] = write_strobe_n_reg;
   assign alt_src[`BIT_HIGH_BYTE] = high_byte_select_reg;
   assign alt_src[`BIT_READ_STROBE] = read_strobe_n_reg;

   // Per-pin driver select; alternate function overrides the latch
   genvar gi;
   generate
      for (gi = 0; gi < 16; gi = gi + 1) begin : g_pin
         always @* begin
            if (alt_function_select_reg[gi]) begin
               pb_out_next[gi] = alt_src[gi];
               pb_oe_next[gi] = 1'b1;
            end else begin
               pb_out_next[gi] = output_latch_reg[gi];
               pb_oe_next[gi] = dir_eff[gi];
            end
         end
      end
   endgenerate

   // Pin drivers registered so the pads see clean edges
   always @(posedge CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         PB_OUT <= 16'h0000;
         PB_OE <= 16'h0000;
      end else begin
         PB_OUT <= pb_out_next;
         PB_OE <= pb_oe_next;
      end
   end

endmodule // bus_gpio_port

/* File: verification/bus_gpio_port_assertions.sv */
module bus_gpio_port_checker (
   input wire CLK,
   input wire NRST,
   input wire [15:0] AD_OUT,
   input wire [15:0] AD_OE,
   input wire [15:0] PB_OUT,
   input wire [15:0] PB_OE
);
   timeunit 1ns;
   timeprecision 1ps;
   // One domain, so clock and reset are given once
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST);

   // Pins start released as inputs
   property p_reset_hiz; $rose(NRST) |-> PB_OE == 16'h0000 && AD_OE == 16'h0000; endproperty
   a_reset_hiz: assert property (p_reset_hiz) else $error("pins driven after reset");
   // Address is driven while the latch strobe rises; past-enable guard skips alt switching
   property p_latch_addr;
      $rose(PB_OUT[10]) && $past(PB_OE[10]) && PB_OE[10] |-> AD_OE == 16'hFFFF;
   endproperty
   a_latch_addr: assert property (p_latch_addr) else $error("no address at latch");
   // Latch strobe stays high for exactly two cycles
   property p_latch_len;
      $rose(PB_OUT[10]) && $past(PB_OE[10]) && PB_OE[10] |=> PB_OUT[10] ##1 !PB_OUT[10];
   endproperty
   a_latch_len: assert property (p_latch_len) else $error("latch strobe length");
   // Address stays on the bus one cycle after the latch falls
   property p_addr_hold;
      $fell(PB_OUT[10]) && $past(PB_OE[10]) && PB_OE[10] |-> $stable(AD_OUT) && AD_OE == 16'hFFFF;
   endproperty
   a_addr_hold: assert property (p_addr_hold) else $error("address not held");
   // Write strobe is low for four cycles
   property p_wr_len;
      $fell(PB_OUT[11]) && $past(PB_OE[11]) && PB_OE[11] |-> !PB_OUT[11] [*4] ##1 PB_OUT[11];
   endproperty
   a_wr_len: assert property (p_wr_len) else $error("write strobe length");
   // Data driven during a write
   property p_wr_drive; PB_OE[11] && !PB_OUT[11] |-> AD_OE == 16'hFFFF; endproperty
   a_wr_drive: assert property (p_wr_drive) else $error("bus idle during write");
   // Bus released during a read so memory can answer
   property p_rd_release; PB_OE[15] && !PB_OUT[15] |-> AD_OE == 16'h0000; endproperty
   a_rd_release: assert property (p_rd_release) else $error("bus driven during read");
   // Read and write strobes never active together
   property p_no_both; PB_OE[11] && PB_OE[15] |-> PB_OUT[11] || PB_OUT[15]; endproperty
   a_no_both: assert property (p_no_both) else $error("both strobes low");
   // Odd address always raises high byte select
   property p_hbs_odd;
      $rose(PB_OUT[10]) && PB_OE[10] && PB_OE[12] && AD_OUT[0] |-> PB_OUT[12];
   endproperty
   a_hbs_odd: assert property (p_hbs_odd) else $error("odd byte without high select");
endmodule // bus_gpio_port_checker

bind bus_gpio_port bus_gpio_port_checker u_chk (
   .CLK(CLK), .NRST(NRST), .AD_OUT(AD_OUT), .AD_OE(AD_OE), .PB_OUT(PB_OUT), .PB_OE(PB_OE)
);

/* File: verification/ext_mem_model.sv */
module ext_mem_model (
   input wire clk,
   input wire [15:0] ad_out,
   input wire [15:0] ad_oe,
   input wire [15:0] pb_out,
   input wire [15:0] pb_oe,
   output wire [15:0] ad_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [0:255];
   logic [7:0] idx;
   logic a0;
   logic [15:0] last = 16'h0000;
   wire rd_act = pb_oe[15] && !pb_out[15];
   // Released bus toggles so a stale value cannot pass for read data
   wire [15:0] drv = rd_act ? mem[idx] : ~last;
   assign ad_in = (ad_oe & ad_out) | (~ad_oe & drv);
   // Address captured while latch is high, data stored during the write strobe
   always @(posedge clk) begin
      last <= ad_in;
      if (pb_oe[10] && pb_out[10]) begin
         idx <= ad_out[8:1];
         a0 <= ad_out[0];
      end
      if (pb_oe[11] && !pb_out[11]) begin
         if (pb_out[12] && !a0) mem[idx] <= ad_out;
         else if (!a0) mem[idx][7:0] <= ad_out[7:0];
         else mem[idx][15:8] <= ad_out[15:8];
      end
   end
endmodule // ext_mem_model

/* File: verification/bus_gpio_port_tb.sv */
`include "gpio_consts.vh"
module bus_gpio_port_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic CLK, NRST, awvalid, wvalid, bready, arvalid, rready;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata;
   logic [3:0] wstrb;
   logic [15:0] pb_ext;
   logic [11:0] per;
   wire awready, wready, bvalid, arready, rvalid;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [15:0] ad_in, ad_out, ad_oe, pb_out, pb_oe, pb_pin;
   logic [33:0] expq[$];
   int n_mismatch = 0;
   int tests_run = 0;
   int cycles = 0;
   integer seed;
   // Pin level resolves the port drive against the external load
   assign pb_pin = (pb_oe & pb_out) | (~pb_oe & pb_ext);

   bus_gpio_port u_dut (
      .CLK(CLK), .NRST(NRST), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
      .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
      .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
      .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
      .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .AD_IN(ad_in), .AD_OUT(ad_out), .AD_OE(ad_oe), .PB_IN(pb_pin), .PB_OUT(pb_out),
      .PB_OE(pb_oe), .UART_TX_OUT(per[0]), .E_STROBE_OUT(per[1]), .UART_CLOCK_PIN(per[2]),
      .TIMER_TWO_PIN(per[3]), .TIMER_THREE_PIN(per[4]), .SERIAL_DATA_OUT(per[5]),
      .SERIAL_CLOCK_OUT(per[6]), .HOLD_ACK_OUT(per[7]), .SYNC_OR_SELECT_OUT(per[11:8])
   );
   ext_mem_model u_mem (
      .clk(CLK), .ad_out(ad_out), .ad_oe(ad_oe), .pb_out(pb_out), .pb_oe(pb_oe), .ad_in(ad_in)
   );

   task complete_run;
      $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task chk(input logic [33:0] g, input logic [33:0] e);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   // Address and data offered together, each released once taken
   task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      logic pa, pw;
      pa = 1'b1;
      pw = 1'b1;
      expq.push_back({r, 32'h0000_0000});
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge CLK);
         if (pa && awready) begin
            awvalid <= 1'b0;
            pa = 1'b0;
         end
         if (pw && wready) begin
            wvalid <= 1'b0;
            pw = 1'b0;
         end
      end while (pa || pw);
      bready <= 1'b1;
      do @(posedge CLK); while (!bvalid);
      bready <= 1'b0;
   endtask

   task axi_rd(input logic [7:0] a, input logic [1:0] r, input logic [31:0] e);
      expq.push_back({r, e});
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge CLK); while (!arready);
      arvalid <= 1'b0;
      rready <= 1'b1;
      do @(posedge CLK); while (!rvalid);
      rready <= 1'b0;
   endtask

   // Responses are matched against the oldest note as they are accepted
   always @(posedge CLK) begin
      if (rvalid && rready) chk({rresp, rdata}, expq.pop_front());
      if (bvalid && bready) chk({bresp, 32'h0000_0000}, expq.pop_front());
   end

   initial begin
      CLK = 1'b0;
      forever #4 CLK = ~CLK;
   end

   // A hang is cut short well beyond the expected run length
   always @(posedge CLK) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         complete_run();
      end
   end

   initial begin
      logic [15:0] d, l, p, dm, s;
      seed = 32'h5721_d9c8;
      {NRST, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
      {awaddr, araddr, wdata, wstrb} = {8'h00, 8'h00, 32'h0000_0000, 4'hF};
      pb_ext = 16'h0000;
      per = 12'h000;
      repeat (2) @(posedge CLK);
      NRST <= 1'b1;
      repeat (3) @(posedge CLK);
      chk(pb_oe, 16'h0000);
      axi_rd(`OFS_PIN_DIRECTION, `RESP_OKAY, 32'h0000_0000);
      axi_rd(`OFS_ALT_FUNCTION_SELECT, `RESP_OKAY, 32'h0000_0000);
      axi_rd(8'h40, `RESP_SLVERR, 32'h0000_0000);
      axi_wr(8'h40, 32'h1234_5678, `RESP_SLVERR);
      repeat (8) begin
         {d, l} = $random(seed);
         {p, s} = $random(seed);
         dm = d & `GPIO_MASK;
         pb_ext <= p;
         axi_wr(`OFS_OUTPUT_LATCH, {16'h0000, l}, `RESP_OKAY);
         axi_wr(`OFS_PIN_DIRECTION, {16'h0000, d}, `RESP_OKAY);
         repeat (4) @(posedge CLK);
         chk(pb_oe, dm);
         chk(pb_out & dm, l & dm);
         axi_rd(`OFS_PIN_DIRECTION, `RESP_OKAY, {16'h0000, dm});
         axi_rd(`OFS_OUTPUT_LATCH, `RESP_OKAY, {16'h0000, (dm & l) | (~dm & p)});
      end
      per <= s[11:0];
      axi_wr(`OFS_ALT_FUNCTION_SELECT, 32'h0000_FFFF, `RESP_OKAY);
      axi_wr(`OFS_OUTPUT_LATCH, {16'h0000, ~l}, `RESP_OKAY);
      repeat (2) @(posedge CLK);
      chk(pb_oe, 16'hFFFF);
      chk(pb_out & `GPIO_MASK, {1'b0, s[11:10], 3'b000, s[9:8], s[7:0]});
      chk({pb_out[15], pb_out[11:10]}, 3'b110);
      // Word write then word read at the same even address
      axi_wr(`OFS_EXT_ADDR, 32'h0000_0024, `RESP_OKAY);
      axi_wr(`OFS_EXT_WDATA, {16'h0000, p}, `RESP_OKAY);
      axi_wr(`OFS_EXT_CTRL, 32'h0000_0003, `RESP_OKAY);
      repeat (12) @(posedge CLK);
      axi_wr(`OFS_EXT_CTRL, 32'h0000_0001, `RESP_OKAY);
      repeat (12) @(posedge CLK);
      axi_rd(`OFS_EXT_STATUS, `RESP_OKAY, {16'h0000, p});
      axi_wr(`OFS_EXT_ADDR, 32'h0000_0025, `RESP_OKAY);
      axi_wr(`OFS_EXT_CTRL, 32'h0000_0005, `RESP_OKAY);
      repeat (12) @(posedge CLK);
      axi_rd(`OFS_EXT_CTRL, `RESP_OKAY, 32'h0000_0004);
      axi_rd(`OFS_EXT_STATUS, `RESP_OKAY, {16'h0000, p});
      axi_wr(`OFS_ALT_FUNCTION_SELECT, 32'h0000_0000, `RESP_OKAY);
      axi_wr(`OFS_PIN_DIRECTION, 32'h0000_FFFF, `RESP_OKAY);
      repeat (2) @(posedge CLK);
      chk(pb_out & `GPIO_MASK, ~l & `GPIO_MASK);
      complete_run();
   end
endmodule // bus_gpio_port_tb
